// >>> pkg/nvc_pkg.sv
/*
  nvc_pkg: constants and carrier types for the host-side controller of a
  2K x 8 nonvolatile-shadowed asynchronous SRAM.
  Assumes a 125 MHz system clock; all pin timing is expressed in cycles.
*/
package nvc_pkg;
  localparam int          CLK_PERIOD_NS      = 8;
  localparam int          ADDR_W             = 11;
  localparam int          DATA_W             = 8;
  // pin phase timing (ns), rounded up to cycles
  localparam int          ACCESS_NS          = 45;
  localparam int          ACCESS_CYC         = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RECOVER_NS         = 16;
  localparam int          RECOVER_CYC        = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // nonvolatile operation durations (least waits, rounded up)
  localparam int          STORE_MS           = 10;
  localparam int          STORE_CYC          = (STORE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NV_LOAD_TIME_US    = 20;
  localparam int          NV_LOAD_CYC        = (NV_LOAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          POWERUP_LOAD_TIME_US = 550;
  localparam int          POWERUP_LOAD_CYC   = (POWERUP_LOAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAIT_W             = 21;
  // unlock sequence addresses
  localparam logic [10:0] SEQ_A0             = 11'h000;
  localparam logic [10:0] SEQ_A1             = 11'h555;
  localparam logic [10:0] SEQ_A2             = 11'h2aa;
  localparam logic [10:0] SEQ_A3             = 11'h7ff;
  localparam logic [10:0] SEQ_A4             = 11'h0f0;
  localparam logic [10:0] SEQ_STORE          = 11'h70f;
  localparam logic [10:0] SEQ_LOAD           = 11'h70e;
  localparam logic [2:0]  SEQ_LEN            = 3'h6;

  typedef enum logic [1:0] {
    NVC_OP_READ,
    NVC_OP_WRITE,
    NVC_OP_STORE,
    NVC_OP_RECALL
  } nvc_op_t;

  typedef struct packed {
    nvc_op_t           op;
    logic [10:0]       addr;
    logic [7:0]        wdata;
  } nvc_req_t;

  typedef struct packed {
    logic              sel_n;
    logic              wr_n;
    logic              oe_n;
    logic [10:0]       addr;
  } nvc_pins_t;
endpackage : nvc_pkg

// >>> hdl/nvc_wait.sv
/*
  nvc_wait: loadable down-counter that times pin phases and nonvolatile
  busy periods. Assumes load and count are synchronous to clock.
*/
module nvc_wait
  import nvc_pkg::*;
#(
  parameter int W = WAIT_W
)(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = load ? value : (cnt_r != '0 ? cnt_r - W'(1) : cnt_r);
  // done must not look at load: the parent derives load from done
  assign done    = (cnt_r == '0);

  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_r <= '0;
    else if (ce)
      cnt_r <= cnt_nxt;
  end
endmodule : nvc_wait

// >>> hdl/nvc_host.sv
/*
  nvc_host: host controller for a 2K x 8 SRAM with nonvolatile shadow.
  Runs reads, writes and the six-access STORE/RECALL unlock sequences (chip
  select only, OE and WE high) on the pins, then waits out the device busy time. Assumes the device pins
  are wired directly; io_bus is split into in/out/enable by the bench.
*/
module nvc_host
  import nvc_pkg::*;
#(
  parameter int STORE_WAIT   = STORE_CYC,
  parameter int LOAD_WAIT    = NV_LOAD_CYC,
  parameter int POWERUP_WAIT = POWERUP_LOAD_CYC
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire nvc_req_t          req,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  input  wire logic              supply_ok,
  output nvc_pins_t              pins,
  input  wire logic [DATA_W-1:0] io_bus_in,
  output logic [DATA_W-1:0]      io_bus_out,
  output logic                   io_bus_oe_n
);
  typedef enum logic [2:0] {
    NVC_ST_POWER,
    NVC_ST_IDLE,
    NVC_ST_ACCESS,
    NVC_ST_RECOVER,
    NVC_ST_BUSY
  } nvc_state_t;

  nvc_state_t          state_r;
  nvc_req_t            cur_r;
  logic [2:0]          step_r;
  logic                sel_n_r;
  logic                wr_n_r;
  logic                oe_n_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [DATA_W-1:0]   dout_r;
  logic                drive_r;
  logic [DATA_W-1:0]   rdata_r;
  logic                rvalid_r;
  logic                supply_r;
  logic                wt_load;
  logic [WAIT_W-1:0]   wt_value;
  logic                wt_done;
  logic                is_seq;
  logic                last_step;
  logic [ADDR_W-1:0]   step_addr;
  logic                take;

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvc_op_t op);
    case (s)
      3'h0:    seq_addr = SEQ_A0;
      3'h1:    seq_addr = SEQ_A1;
      3'h2:    seq_addr = SEQ_A2;
      3'h3:    seq_addr = SEQ_A3;
      3'h4:    seq_addr = SEQ_A4;
      default: seq_addr = (op == NVC_OP_STORE) ? SEQ_STORE : SEQ_LOAD;
    endcase
  endfunction : seq_addr

  assign is_seq    = (cur_r.op == NVC_OP_STORE) || (cur_r.op == NVC_OP_RECALL);
  assign last_step = (step_r == SEQ_LEN - 3'h1);
  // below the trip level nothing is taken: a store is refused, others would be lost to the brownout
  assign req_ready = (state_r == NVC_ST_IDLE) && supply_ok;
  assign take      = req_valid && req_ready;
  assign step_addr = seq_addr(step_r, cur_r.op);

  // wait timer loads at each phase entry
  always_comb
  begin
    wt_load  = 1'b0;
    wt_value = '0;
    if (state_r == NVC_ST_POWER && supply_ok && !supply_r)
    begin
      wt_load  = 1'b1;
      wt_value = WAIT_W'(POWERUP_WAIT);
    end
    else if (take)
    begin
      wt_load  = 1'b1;
      wt_value = WAIT_W'(ACCESS_CYC);
    end
    else if (state_r == NVC_ST_ACCESS && wt_done)
    begin
      wt_load  = 1'b1;
      wt_value = WAIT_W'(RECOVER_CYC);
    end
    else if (state_r == NVC_ST_RECOVER && wt_done)
    begin
      wt_load = 1'b1;
      if (is_seq && last_step)
        wt_value = (cur_r.op == NVC_OP_STORE) ? WAIT_W'(STORE_WAIT) : WAIT_W'(LOAD_WAIT);
      else
        wt_value = WAIT_W'(ACCESS_CYC);
    end
  end

  nvc_wait #(
    .W     (WAIT_W)
  ) u_wait (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .load  (wt_load),
    .value (wt_value),
    .done  (wt_done)
  );

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r  <= NVC_ST_POWER;
      cur_r    <= '0;
      step_r   <= 3'h0;
      supply_r <= 1'b0;
    end
    else if (ce)
    begin
      supply_r <= supply_ok;
      case (state_r)
        NVC_ST_POWER:
          // recall latched at power loss, wait restore after trip
          if (!supply_ok)
            state_r <= NVC_ST_POWER;
          else if (supply_r && wt_done)
            state_r <= NVC_ST_IDLE;
        NVC_ST_IDLE:
          if (take)
          begin
            cur_r   <= req;
            step_r  <= 3'h0;
            state_r <= NVC_ST_ACCESS;
          end
        NVC_ST_ACCESS:
          if (wt_done)
            state_r <= NVC_ST_RECOVER;
        NVC_ST_RECOVER:
          if (wt_done)
          begin
            if (is_seq && !last_step)
            begin
              step_r  <= step_r + 3'h1;
              state_r <= NVC_ST_ACCESS;
            end
            else if (is_seq)
              state_r <= NVC_ST_BUSY;
            else
              state_r <= NVC_ST_IDLE;
          end
        NVC_ST_BUSY:
          if (wt_done)
          begin
            step_r  <= 3'h0;
            state_r <= NVC_ST_IDLE;
          end
        default:
          state_r <= NVC_ST_POWER;
      endcase
      // brownout aborts everything and relatches the power-up recall
      if (!supply_ok && state_r != NVC_ST_POWER)
        state_r <= NVC_ST_POWER;
    end
  end

  // pin drivers; strobes only active in the access phase
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sel_n_r  <= 1'b1;
      wr_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      addr_r   <= '0;
      dout_r   <= '0;
      drive_r  <= 1'b0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end
    else if (ce)
    begin
      rvalid_r <= 1'b0;
      if (take)
        addr_r <= (req.op == NVC_OP_READ || req.op == NVC_OP_WRITE) ? req.addr : SEQ_A0;
      else if (state_r == NVC_ST_RECOVER && wt_done && is_seq && !last_step)
        addr_r <= seq_addr(step_r + 3'h1, cur_r.op);
      if (state_r == NVC_ST_ACCESS && !wt_done)
      begin
        sel_n_r <= 1'b0;
        wr_n_r  <= (cur_r.op != NVC_OP_WRITE);
        oe_n_r  <= (cur_r.op != NVC_OP_READ);
        drive_r <= (cur_r.op == NVC_OP_WRITE);
        dout_r  <= cur_r.wdata;
      end
      else
      begin
        sel_n_r <= 1'b1;
        wr_n_r  <= 1'b1;
        oe_n_r  <= 1'b1;
        // keep data one cycle past strobe rise for hold time
        drive_r <= drive_r && (state_r == NVC_ST_ACCESS);
      end
      if (state_r == NVC_ST_ACCESS && wt_done && cur_r.op == NVC_OP_READ)
      begin
        rdata_r  <= io_bus_in;
        rvalid_r <= 1'b1;
      end
    end
  end

  assign pins.sel_n  = sel_n_r;
  assign pins.wr_n   = wr_n_r;
  assign pins.oe_n   = oe_n_r;
  assign pins.addr   = addr_r;
  assign io_bus_out  = dout_r;
  assign io_bus_oe_n = !drive_r;
  assign rsp_valid   = rvalid_r;
  assign rsp_data    = rdata_r;
endmodule : nvc_host

// >>> tb/nvc_host_assertions.sv
/* nvc_host_assertions: pin and handshake checks for nvc_host.
   Assumes a bind to nvc_host; sees only its ports. */
module nvc_host_assertions
  import nvc_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic              req_ready,
  input wire nvc_req_t          req,
  input wire logic              rsp_valid,
  input wire logic              supply_ok,
  input wire nvc_pins_t         pins,
  input wire logic [DATA_W-1:0] io_bus_out,
  input wire logic              io_bus_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence sel_low_s;
    !pins.sel_n [*4];
  endsequence
  sequence wr_end_s;
    !io_bus_oe_n ##0 $stable(io_bus_out);
  endsequence
  read_oe_a: assert property (!pins.oe_n |-> pins.wr_n && io_bus_oe_n)
    else $error("oe low outside read");
  write_oe_a: assert property (!pins.wr_n |-> pins.oe_n && !io_bus_oe_n && !pins.sel_n)
    else $error("bad write strobes");
  addr_hold_a: assert property (!pins.sel_n && !$past(pins.sel_n) |-> $stable(pins.addr))
    else $error("address moved while selected");
  wr_fall_a: assert property ($fell(pins.wr_n) |-> $fell(pins.sel_n))
    else $error("write without select");
  data_hold_a: assert property ($rose(pins.wr_n) |-> wr_end_s)
    else $error("write data not held");
  sel_pulse_a: assert property ($fell(pins.sel_n) |-> sel_low_s)
    else $error("select pulse short");
  store_refuse_a: assert property (!supply_ok && req.op == NVC_OP_STORE |-> !req_ready)
    else $error("store taken at low supply");
  rsp_pulse_a: assert property (rsp_valid && ce |=> !rsp_valid)
    else $error("response too long");
endmodule : nvc_host_assertions

bind nvc_host nvc_host_assertions u_chk (.clock, .rst, .ce, .req_ready, .req, .rsp_valid,
  .supply_ok, .pins, .io_bus_out, .io_bus_oe_n);

// >>> tb/nvc_mem_model.sv
/* nvc_mem_model: 2K x 8 SRAM with nonvolatile shadow, behavioural.
   Assumes the bench resolves the data bus from the host enable alone. */
module nvc_mem_model
  import nvc_pkg::*;
(
  input  wire logic        sel_n,
  input  wire logic        wr_n,
  input  wire logic        oe_n,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  dq_in,
  input  wire logic        supply_ok,
  output logic      [7:0]  dq_out,
  output logic             dq_drv,
  output logic      [7:0]  stores,
  output logic      [7:0]  recalls
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  sram [2048] = '{default: 8'h00};
  logic [7:0]  shadow [2048] = '{default: 8'h00};
  logic [10:0] order [5] = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0};
  logic [7:0]  last_q = 8'h00;
  logic        wr_act = 1'b0;
  logic        busy = 1'b0;
  int          step = 0;
  initial {stores, recalls} = 16'h0000;
  assign dq_drv = !sel_n && !oe_n && wr_n && !busy;
  // released bus shows the inverse of the last byte
  assign dq_out = dq_drv ? sram[addr] : ~last_q;
  always @* if (dq_drv) last_q = sram[addr];
  always @* if (!sel_n && !wr_n && !busy) wr_act = 1'b1;
  always @(posedge sel_n or posedge wr_n)
    if (wr_act)
    begin
      sram[addr] = dq_in;
      wr_act = 1'b0;
    end
  always @(posedge supply_ok) sram = shadow;
  // let the write strobe launched at the same edge settle before it is looked at
  always @(negedge sel_n) #1
    if (!busy)
    begin
      if (!wr_n)
        step = 0;
      else if (step == 5 && (addr == 11'h70f || addr == 11'h70e))
      begin
        step = 0;
        if (addr[0] && supply_ok)
        begin
          shadow = sram;
          stores++;
          busy = 1'b1;
          busy <= #150 1'b0;
        end
        else if (!addr[0])
        begin
          sram = shadow;
          recalls++;
          busy = 1'b1;
          busy <= #70 1'b0;
        end
      end
      else
        step = (step < 5 && addr == order[step]) ? step + 1 : int'(addr == 11'h000);
    end
endmodule : nvc_mem_model

// >>> tb/nvc_host_bench.sv
/* nvc_host_bench: random and directed traffic through nvc_host.
   Assumes nvc_mem_model stands for the device. */
module nvc_host_bench
  import nvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        req_valid = 1'b0;
  logic        supply_ok = 1'b1;
  logic        req_ready, rsp_valid, dq_drv, io_oe_n;
  nvc_req_t    req = '0;
  nvc_pins_t   pins;
  logic [7:0]  rsp_data, io_in, io_out, dq_out, stores, recalls;
  logic [7:0]  nv [2048];
  logic [7:0]  mem [2048] = '{default: 8'h00};
  logic [10:0] a;
  logic [7:0]  d;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed = 32'h2445cc18;
  assign io_in = io_oe_n ? dq_out : io_out;
  nvc_host #(.STORE_WAIT(20), .LOAD_WAIT(10), .POWERUP_WAIT(15)) u_dut (.clock, .rst, .ce, .req_valid,
    .req_ready, .req, .rsp_valid, .rsp_data, .supply_ok, .pins, .io_bus_in(io_in), .io_bus_out(io_out),
    .io_bus_oe_n(io_oe_n));
  nvc_mem_model u_mem (.sel_n(pins.sel_n), .wr_n(pins.wr_n), .oe_n(pins.oe_n), .addr(pins.addr),
    .dq_in(io_in), .supply_ok, .dq_out, .dq_drv, .stores, .recalls);
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    ce <= rst || (($random(seed) & 7) != 0);
    if (!rst)
      check({7'h00, dq_drv && !io_oe_n}, 8'h00);
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic do_req(input nvc_op_t op, input logic [10:0] ad, input logic [7:0] wd, input logic [7:0] exp);
    @(posedge clock);
    req <= '{op, ad, wd};
    req_valid <= 1'b1;
    do @(posedge clock); while (!(req_ready && ce));
    req_valid <= 1'b0;
    if (op == NVC_OP_READ)
    begin
      do @(posedge clock); while (!rsp_valid);
      check(rsp_data, exp);
    end
  endtask : do_req
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({4'h0, pins.sel_n, pins.wr_n, pins.oe_n, io_oe_n}, 8'h0f);
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      a = (i == 0) ? 11'h7ff : 11'($random(seed));
      d = 8'($random(seed));
      do_req(NVC_OP_WRITE, a, d, 8'h00);
      mem[a] = d;
      do_req(NVC_OP_READ, a, 8'h00, d);
      do_req(NVC_OP_READ, a ^ 11'h001, 8'h00, mem[a ^ 11'h001]);
    end
    $display("test read write done");
    do_req(NVC_OP_STORE, 11'h000, 8'h00, 8'h00);
    nv = mem;
    do_req(NVC_OP_WRITE, a, ~d, 8'h00);
    check(stores, 8'h01);
    do_req(NVC_OP_READ, a, 8'h00, ~d);
    do_req(NVC_OP_RECALL, 11'h000, 8'h00, 8'h00);
    do_req(NVC_OP_READ, a, 8'h00, nv[a]);
    check(recalls, 8'h01);
    $display("test store recall done");
    do_req(NVC_OP_WRITE, a, 8'h5a, 8'h00);
    do @(posedge clock); while (!req_ready);
    supply_ok <= 1'b0;
    req <= '{NVC_OP_STORE, 11'h000, 8'h00};
    req_valid <= 1'b1;
    repeat (4) @(posedge clock);
    check({7'h00, req_ready}, 8'h00);
    req_valid <= 1'b0;
    supply_ok <= 1'b1;
    do_req(NVC_OP_READ, a, 8'h00, nv[a]);
    check(stores, 8'h01);
    $display("test brownout done");
    results();
  end
endmodule : nvc_host_bench
